// File: verilog/dbkc_pkg.sv
// Constants shared by the debug breakpoint control block.
// Assumes a 25 MHz system clock and a separate debug link clock.
`default_nettype none

package dbkc_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam int unsigned DBKC_ADDR_W = 8;
	localparam int unsigned DBKC_DATA_W = 8;
	localparam logic [7:0] DBKC_BREAK_CONTROL_OFFSET = 8'h10;
	localparam logic [7:0] DBKC_BREAK_CONTROL_RESET = 8'h00;

	// ********************************************************
	// Break control fields
	// ********************************************************
	localparam int unsigned DBKC_BIT_BREAK_NEXT = 7;
	localparam int unsigned DBKC_BIT_MATCH0_EN = 3;
	localparam int unsigned DBKC_BIT_IGNORE_LOW1 = 2;
	localparam int unsigned DBKC_BIT_IGNORE_LOW0 = 1;
	localparam int unsigned DBKC_BIT_SINGLE_STEP = 0;

	// ********************************************************
	// Comparators and address
	// ********************************************************
	localparam int unsigned DBKC_NUM_MATCH = 4;
	localparam int unsigned DBKC_CPU_ADDR_W = 24;
	localparam int unsigned DBKC_LOW_BYTE_W = 8;
	localparam int unsigned DBKC_SHORT_ADDR_W = 16;
	localparam logic [3:0] DBKC_IGNORE_CAPABLE = 4'h3;

	// ********************************************************
	// Synchronisers and strap timing
	// ********************************************************
	localparam int unsigned DBKC_SYNC_STAGES = 3;
	localparam logic [1:0] DBKC_STRAP_WAIT = 2'h3;

	typedef enum logic
	{
		DBKC_CPU_RUN = 1'b0,
		DBKC_CPU_HALTED = 1'b1
	} dbkc_cpu_state_t;

endpackage

`default_nettype wire

// File: verilog/dbkc_break_control.sv
// Breakpoint control for the serial debug interface: break control
// register, four address comparators, single step and reset strap.
// Assumes the CPU marks first opcode fetches and instruction ends.
// Assumes the link clock keeps running until reg_busy_o falls.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Write-only 8-bit break control, reset zero
// - Clearing break-next releases the held CPU
// - Break-next set halts before next instruction
// - Halt only at first opcode byte
// - Strap clock high, data low sets break-next
// - Address match break sets break-next
// - Host writing one forces next-boundary break
// - Bits six to three enable comparators
// - Comparator one full 24-bit match
// - Comparator one ignore-low matches 256-byte page
// - Comparator zero full 24-bit match
// - Comparator zero ignore-low matches upper bytes
// - Single step breaks after each instruction
// - Compare address depends on wide mode
// - Mid-instruction match breaks at instruction end
module dbkc_break_control
	import dbkc_pkg::*;
#(
	parameter int unsigned NUM_MATCH = dbkc_pkg::DBKC_NUM_MATCH
)
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	input wire logic reg_wr_i,
	input wire logic [dbkc_pkg::DBKC_ADDR_W-1:0] reg_addr_i,
	input wire logic [dbkc_pkg::DBKC_DATA_W-1:0] reg_wdata_i,
	output logic reg_busy_o,
	input wire logic debug_clock_pin_i,
	input wire logic debug_data_pin_i,
	input wire logic [dbkc_pkg::DBKC_CPU_ADDR_W-1:0] match0_addr_i,
	input wire logic [dbkc_pkg::DBKC_CPU_ADDR_W-1:0] match1_addr_i,
	input wire logic [dbkc_pkg::DBKC_CPU_ADDR_W-1:0] match2_addr_i,
	input wire logic [dbkc_pkg::DBKC_CPU_ADDR_W-1:0] match3_addr_i,
	input wire logic [dbkc_pkg::DBKC_CPU_ADDR_W-1:0] cpu_addr_i,
	input wire logic wide_address_mode_i,
	input wire logic [dbkc_pkg::DBKC_LOW_BYTE_W-1:0] memory_base_byte_i,
	input wire logic cpu_fetch_i,
	input wire logic cpu_first_fetch_i,
	input wire logic cpu_instr_done_i,
	output logic break_req_o,
	output logic cpu_halt_o
);
	import dbkc_pkg::*;

	// ********************************************************
	// Link domain: write capture and handshake
	// ********************************************************
	logic [DBKC_DATA_W-1:0] link_data_q;
	logic link_req_q;
	logic [DBKC_SYNC_STAGES-1:0] link_ack_sync_q;
	logic link_busy;
	logic link_take;
	logic sys_ack_q;

	// Busy until the returned toggle stands in the last two stages
	assign link_busy = (link_req_q != link_ack_sync_q[DBKC_SYNC_STAGES-1])
		|| (link_ack_sync_q[DBKC_SYNC_STAGES-1] != link_ack_sync_q[1]);
	assign link_take = reg_wr_i && !link_busy && (reg_addr_i == DBKC_BREAK_CONTROL_OFFSET);
	assign reg_busy_o = link_busy;

	// Data held stable until the system side has acknowledged
	always_ff @(posedge link_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			link_data_q <= DBKC_BREAK_CONTROL_RESET;
			link_req_q <= 1'b0;
		end
		else if (link_take)
		begin
			link_data_q <= reg_wdata_i;
			link_req_q <= ~link_req_q;
		end
	end

	always_ff @(posedge link_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			link_ack_sync_q <= '0;
		else
			link_ack_sync_q <= {link_ack_sync_q[DBKC_SYNC_STAGES-2:0], sys_ack_q};
	end

	// ********************************************************
	// System domain: request synchroniser
	// ********************************************************
	logic [DBKC_SYNC_STAGES-1:0] sys_req_sync_q;
	logic host_write;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sys_req_sync_q <= '0;
		else
			sys_req_sync_q <= {sys_req_sync_q[DBKC_SYNC_STAGES-2:0], link_req_q};
	end

	// Toggle counted once the last two stages agree on a new level
	assign host_write = (sys_req_sync_q[DBKC_SYNC_STAGES-1] == sys_req_sync_q[1])
		&& (sys_req_sync_q[1] != sys_ack_q);

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sys_ack_q <= 1'b0;
		else if (host_write)
			sys_ack_q <= sys_req_sync_q[1];
	end

	// ********************************************************
	// Reset strap sampling
	// ********************************************************
	logic [DBKC_SYNC_STAGES-1:0] strap_clk_sync_q;
	logic [DBKC_SYNC_STAGES-1:0] strap_data_sync_q;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic strap_set;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_clk_sync_q <= '0;
			strap_data_sync_q <= '0;
		end
		else
		begin
			strap_clk_sync_q <= {strap_clk_sync_q[DBKC_SYNC_STAGES-2:0], debug_clock_pin_i};
			strap_data_sync_q <= {strap_data_sync_q[DBKC_SYNC_STAGES-2:0], debug_data_pin_i};
		end
	end

	// Pins are only valid once the synchronisers have filled
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			strap_cnt_q <= '0;
		else if (strap_cnt_q != DBKC_STRAP_WAIT)
			strap_cnt_q <= strap_cnt_q + 2'h1;
	end

	// Sampled once; later pin activity is link traffic, not a strap
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			strap_done_q <= 1'b0;
		else if (strap_cnt_q == DBKC_STRAP_WAIT)
			strap_done_q <= 1'b1;
	end

	// Third stage holds a pin sample only once the count has saturated
	assign strap_set = !strap_done_q && (strap_cnt_q == DBKC_STRAP_WAIT)
		&& strap_clk_sync_q[DBKC_SYNC_STAGES-1] && strap_clk_sync_q[1]
		&& !strap_data_sync_q[DBKC_SYNC_STAGES-1] && !strap_data_sync_q[1];

	// ********************************************************
	// Address comparators
	// ********************************************************
	logic [DBKC_CPU_ADDR_W-1:0] cmp_addr;
	logic [DBKC_CPU_ADDR_W-1:0] match_addr [NUM_MATCH];
	logic [NUM_MATCH-1:0] match_hit;
	logic [DBKC_DATA_W-1:0] ctrl_q;

	// Short mode extends the 16-bit address with the base byte
	assign cmp_addr = wide_address_mode_i ? cpu_addr_i
		: {memory_base_byte_i, cpu_addr_i[DBKC_SHORT_ADDR_W-1:0]};

	assign match_addr[0] = match0_addr_i;
	assign match_addr[1] = match1_addr_i;
	assign match_addr[2] = match2_addr_i;
	assign match_addr[3] = match3_addr_i;

	generate
		for (genvar i = 0; i < NUM_MATCH; i++)
		begin : g_match
			logic ignore_low;
			logic upper_eq;
			logic low_eq;
			// Only comparators 0 and 1 have an ignore-low control
			if (DBKC_IGNORE_CAPABLE[i])
			begin : g_ign
				assign ignore_low = ctrl_q[DBKC_BIT_IGNORE_LOW0 + i];
			end
			else
			begin : g_full
				assign ignore_low = 1'b0;
			end
			assign upper_eq = cmp_addr[DBKC_CPU_ADDR_W-1:DBKC_LOW_BYTE_W]
				== match_addr[i][DBKC_CPU_ADDR_W-1:DBKC_LOW_BYTE_W];
			assign low_eq = cmp_addr[DBKC_LOW_BYTE_W-1:0]
				== match_addr[i][DBKC_LOW_BYTE_W-1:0];
			assign match_hit[i] = ctrl_q[DBKC_BIT_MATCH0_EN + i] && upper_eq
				&& (ignore_low || low_eq);
		end
	endgenerate

	// ********************************************************
	// Break sources
	// ********************************************************
	logic any_hit;
	logic hit_first;
	logic hit_later;
	logic deferred_q;
	logic defer_fire;
	logic step_fire;
	logic hw_set;

	assign any_hit = |match_hit;
	assign hit_first = cpu_fetch_i && cpu_first_fetch_i && any_hit;
	assign hit_later = cpu_fetch_i && !cpu_first_fetch_i && any_hit;

	// A mid-instruction hit waits for the instruction end
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			deferred_q <= 1'b0;
		else if (cpu_instr_done_i)
			deferred_q <= 1'b0;
		else if (hit_later)
			deferred_q <= 1'b1;
	end

	// Deferred hits and single step both land on the instruction end
	assign defer_fire = cpu_instr_done_i && (deferred_q || hit_later);
	assign step_fire = cpu_instr_done_i && ctrl_q[DBKC_BIT_SINGLE_STEP];
	assign hw_set = hit_first || defer_fire || step_fire || strap_set;

	// ********************************************************
	// Break control register
	// ********************************************************
	logic [DBKC_DATA_W-1:0] ctrl_d;

	// Hardware set wins over a host clear arriving the same cycle
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (host_write)
			ctrl_d = link_data_q;
		if (hw_set)
			ctrl_d[DBKC_BIT_BREAK_NEXT] = 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_q <= DBKC_BREAK_CONTROL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	// ********************************************************
	// CPU halt state
	// ********************************************************
	dbkc_cpu_state_t cpu_state_q;
	logic halt_now;
	logic break_next;

	assign break_next = ctrl_q[DBKC_BIT_BREAK_NEXT];
	// Break only taken on a first opcode fetch
	assign halt_now = cpu_fetch_i && cpu_first_fetch_i && (break_next || any_hit);

	// Limitation: a comparator still matching the re-presented fetch
	// halts again, so the host disables it before clearing break-next

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cpu_state_q <= DBKC_CPU_RUN;
		else
		begin
			unique case (cpu_state_q)
				DBKC_CPU_RUN:
				begin
					if (halt_now)
						cpu_state_q <= DBKC_CPU_HALTED;
				end
				DBKC_CPU_HALTED:
				begin
					if (!break_next)
						cpu_state_q <= DBKC_CPU_RUN;
				end
			endcase
		end
	end

	// Stall covers the fetch cycle itself so no opcode slips through
	assign cpu_halt_o = (cpu_state_q == DBKC_CPU_HALTED) || halt_now;
	assign break_req_o = break_next;

endmodule

`default_nettype wire

// File: bench/dbkc_break_props.sv
// Assertions on the breakpoint control top ports.
// Assumes binding into dbkc_break_control.
`timescale 1ns/1ps
`default_nettype none
module dbkc_break_props
	import dbkc_pkg::*;
#(
	parameter int unsigned NUM_MATCH = 4
)
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	input wire logic reg_wr_i,
	input wire logic [dbkc_pkg::DBKC_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_busy_o,
	input wire logic cpu_fetch_i,
	input wire logic cpu_first_fetch_i,
	input wire logic break_req_o,
	input wire logic cpu_halt_o
);
	// ****
	// CPU side
	// ****
	a_halt_first_only: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(cpu_halt_o) |-> cpu_fetch_i && cpu_first_fetch_i) else $error("Bad halt");
	a_req_halts: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		break_req_o && cpu_fetch_i && cpu_first_fetch_i |-> cpu_halt_o) else $error("No halt");
	a_halt_sets_req: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(cpu_halt_o) |=> break_req_o) else $error("Halt without break-next");
	a_halt_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		cpu_halt_o && break_req_o |=> cpu_halt_o) else $error("Halt dropped");
	a_halt_release: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(cpu_halt_o) |-> !break_req_o) else $error("Released while set");
	a_req_clear_wr: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(break_req_o) |-> reg_busy_o) else $error("Clear without write");
	// ****
	// Link side
	// ****
	a_write_busy: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		reg_wr_i && reg_addr_i == DBKC_BREAK_CONTROL_OFFSET && !reg_busy_o |=> reg_busy_o)
		else $error("Write not taken");
	a_other_ignored: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		reg_wr_i && reg_addr_i != DBKC_BREAK_CONTROL_OFFSET && !reg_busy_o |=> !reg_busy_o)
		else $error("Other address taken");
	c_halt: cover property (@(posedge ref_clk_i) $rose(cpu_halt_o));
	c_clear: cover property (@(posedge ref_clk_i) $fell(break_req_o));
	c_busy: cover property (@(posedge link_clk_i) $rose(reg_busy_o));
endmodule
bind dbkc_break_control dbkc_break_props #(.NUM_MATCH(NUM_MATCH)) u_props (.ref_clk_i,
	.resetn_i, .link_clk_i, .reg_wr_i, .reg_addr_i, .reg_busy_o, .cpu_fetch_i,
	.cpu_first_fetch_i, .break_req_o, .cpu_halt_o);
`default_nettype wire

// File: bench/dbkc_debug_host.sv
// Debug host model: register writes on its own link clock.
// Assumes busy rises after each accepted write.
`timescale 1ns/1ps
`default_nettype none
module dbkc_debug_host
(
	input wire logic reg_busy_i,
	output logic link_clk_o,
	output logic reg_wr_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	// ****
	// Link clock and writes
	// ****
	logic run = 1'h1;
	initial link_clk_o = 1'h0;
	initial reg_wr_o = 1'h0;
	initial reg_addr_o = 8'h00;
	initial reg_wdata_o = 8'h00;
	// Clock stands low between writes
	always #15 link_clk_o = run ? ~link_clk_o : 1'h0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		run = 1'h1;
		@(negedge link_clk_o);
		reg_wr_o = 1'h1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge link_clk_o);
		reg_wr_o = 1'h0;
		// Released lines show a changed value
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
		for (int i = 0; i < 4 && reg_busy_i !== 1'h1; i++)
			@(negedge link_clk_o);
		for (int i = 0; i < 60 && reg_busy_i !== 1'h0; i++)
			@(negedge link_clk_o);
		run = 1'h0;
	endtask
endmodule
`default_nettype wire

// File: bench/dbkc_break_control_bench.sv
// Bench for the breakpoint control: writes through the host model,
// CPU fetches driven on the falling system clock edge.
`timescale 1ns/1ps
`default_nettype none
module dbkc_break_control_bench;
	import dbkc_pkg::*;
	// ****
	// Stimulus and checks
	// ****
	logic ref_clk_i = 1'h0, resetn_i = 1'h0, fe = 1'h0, ff = 1'h0, dn = 1'h0, wide = 1'h1;
	logic sclk = 1'h1, sdat = 1'h0, lclk, wr, busy, brk, halt;
	logic [7:0] ad, wd, mb = 8'h12;
	logic [23:0] ca = 24'h00_0000;
	logic [11:0] te = 12'h5AD;
	logic [7:0] tc [12] = '{8'h08, 8'h08, 8'h0A, 8'h10, 8'h10, 8'h14, 8'h14, 8'h20, 8'h40,
		8'h00, 8'h08, 8'h02};
	logic [23:0] ta [12] = '{24'h12_3456, 24'h12_3457, 24'h12_34FF, 24'h65_4321, 24'h65_4300,
		24'h65_4300, 24'h65_4400, 24'h00_AA55, 24'h7F_0F0F, 24'h7F_0F0F, 24'h99_3456, 24'h12_34FF};
	int error_cnt = 0;
	int samples_checked = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	dbkc_debug_host u_host (.reg_busy_i(busy), .link_clk_o(lclk), .reg_wr_o(wr),
		.reg_addr_o(ad), .reg_wdata_o(wd));
	dbkc_break_control u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_clk_i(lclk),
		.reg_wr_i(wr), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_busy_o(busy),
		.debug_clock_pin_i(sclk), .debug_data_pin_i(sdat), .match0_addr_i(24'h12_3456),
		.match1_addr_i(24'h65_4321), .match2_addr_i(24'h00_AA55), .match3_addr_i(24'h7F_0F0F),
		.cpu_addr_i(ca), .wide_address_mode_i(wide), .memory_base_byte_i(mb),
		.cpu_fetch_i(fe), .cpu_first_fetch_i(ff), .cpu_instr_done_i(dn),
		.break_req_o(brk), .cpu_halt_o(halt));
	task automatic chk(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic fetch(input logic [23:0] a, input logic f, input logic e);
		@(negedge ref_clk_i);
		ca = a;
		fe = 1'h1;
		ff = f;
		#5;
		chk("cpu_halt_o", e, halt);
		@(negedge ref_clk_i);
		fe = 1'h0;
		ff = 1'h0;
	endtask
	task automatic wr_ctl(input logic [7:0] a, input logic [7:0] d, input logic e);
		u_host.wr(a, d);
		repeat (2) @(negedge ref_clk_i);
		chk("break_req_o", e, brk);
	endtask
	task automatic clr;
		wr_ctl(8'h10, 8'h00, 1'h0);
		chk("cpu_halt_o", 1'h0, halt);
	endtask
	task automatic step(input logic e);
		@(negedge ref_clk_i);
		dn = 1'h1;
		@(negedge ref_clk_i);
		dn = 1'h0;
		chk("break_req_o", e, brk);
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		error_cnt++;
		give_verdict;
	end
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		resetn_i = 1'h1;
		repeat (4) @(negedge ref_clk_i);
		sclk = 1'h0;
		sdat = 1'h1;
		chk("break_req_o", 1'h1, brk);
		fetch(24'h00_0100, 1'h0, 1'h0);
		fetch(24'h00_0101, 1'h1, 1'h1);
		wr_ctl(8'h11, 8'h00, 1'h1);
		chk("cpu_halt_o", 1'h1, halt);
		clr;
		wr_ctl(8'h10, 8'h80, 1'h1);
		fetch(24'h00_0102, 1'h1, 1'h1);
		clr;
		for (int i = 0; i < 12; i++)
		begin
			wide = (i != 10);
			wr_ctl(8'h10, tc[i], 1'h0);
			fetch(ta[i], 1'h1, te[i]);
			chk("break_req_o", te[i], brk);
			clr;
		end
		wr_ctl(8'h10, 8'h08, 1'h0);
		fetch(24'h12_3456, 1'h0, 1'h0);
		step(1'h1);
		fetch(24'h00_0200, 1'h1, 1'h1);
		clr;
		wr_ctl(8'h10, 8'h01, 1'h0);
		step(1'h1);
		clr;
		step(1'h0);
		give_verdict;
	end
endmodule
`default_nettype wire
